/* File: rtl/cerr_consts.svh */
// constants for the cable echo result register bank
`ifndef CERR_CONSTS_SVH
`define CERR_CONSTS_SVH

// bus geometry
`define CERR_ADDR_W               12
`define CERR_IDX_W                10
`define CERR_DATA_W               32
`define CERR_BE_W                 4

// echo geometry
`define CERR_PAIRS                4
`define CERR_PEAKS                5
`define CERR_ECHOES               20
`define CERR_WORDS                10
`define CERR_POS_W                8
`define CERR_STR_W                7

// register indices, byte address is four times the index
`define CERR_IDX_ECHO_POSITION_PAIR_1  10'h190
`define CERR_IDX_ECHO_POSITION_PAIR_2  10'h191
`define CERR_IDX_ECHO_POSITION_PAIR_3  10'h192
`define CERR_IDX_ECHO_POSITION_PAIR_4  10'h193
`define CERR_IDX_ECHO_POSITION_PAIR_5  10'h194
`define CERR_IDX_ECHO_POSITION_PAIR_6  10'h195
`define CERR_IDX_ECHO_POSITION_PAIR_7  10'h196
`define CERR_IDX_ECHO_POSITION_PAIR_8  10'h197
`define CERR_IDX_ECHO_POSITION_PAIR_9  10'h198
`define CERR_IDX_ECHO_POSITION_PAIR_10 10'h199
`define CERR_IDX_ECHO_STRENGTH_PAIR_1  10'h19A
`define CERR_IDX_ECHO_STRENGTH_PAIR_2  10'h19B
`define CERR_IDX_ECHO_STRENGTH_LAST    10'h1A3
`define CERR_IDX_CTRL                  10'h1A8
`define CERR_IDX_STATUS                10'h1A9

// field positions
`define CERR_CTRL_FREEZE_BIT      0
`define CERR_STAT_VALID_BIT       0
`define CERR_STAT_MISSED_BIT      1

// reset values
`define CERR_POS_RESET            8'h00
`define CERR_STR_RESET            7'h00
`define CERR_COUNT_RESET          8'h00

// avalon response codes
`define CERR_RESP_OKAY            2'h0
`define CERR_RESP_SLVERR          2'h2

`endif

/* File: rtl/cerr_pkg.sv */
// types shared by the cable echo result register bank
package cerr_pkg;

`include "cerr_consts.svh"

   typedef enum logic [1:0] {
      CERR_IDLE = 2'h0,
      CERR_ACK  = 2'h1
   } cerr_state_e;

   typedef logic [`CERR_POS_W-1:0] cerr_pos_t;
   typedef logic [`CERR_STR_W-1:0] cerr_str_t;

   // entry index is pair * 5 + peak, pair a = 0, first peak = 0
   typedef struct packed {
      cerr_pos_t [`CERR_ECHOES-1:0] position;
      cerr_str_t [`CERR_ECHOES-1:0] strength;
   } cerr_result_s;

   typedef struct packed {
      logic freeze;
   } cerr_ctrl_s;

   typedef struct packed {
      logic [7:0] count;
      logic       busy;
      logic       missed;
      logic       valid;
   } cerr_status_s;

endpackage

/* File: rtl/cerr_regs.sv */
// cable echo result registers behind an avalon-mm slave
//
// Implementation choice: the Avalon-MM register port.

`include "cerr_consts.svh"

module cerr_regs
   import cerr_pkg::*;
(
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    reset,
   // avalon-mm slave
   input  wire logic [`CERR_ADDR_W-1:0] avs_address,
   input  wire logic                    avs_read,
   input  wire logic                    avs_write,
   input  wire logic [`CERR_DATA_W-1:0] avs_writedata,
   input  wire logic [`CERR_BE_W-1:0]   avs_byteenable,
   output      logic [`CERR_DATA_W-1:0] avs_readdata,
   output      logic                    avs_waitrequest,
   output      logic [1:0]              avs_response,
   // measurement engine
   input  wire logic                    meas_done,
   input  wire logic                    meas_busy,
   input  wire cerr_result_s            meas_result,
   // status to the rest of the device
   output      logic                    result_valid
);

   cerr_state_e                state_reg;
   cerr_state_e                state_next;
   logic                       wait_reg;
   logic                       wait_next;
   logic [`CERR_DATA_W-1:0]    rdata_reg;
   logic [`CERR_DATA_W-1:0]    rdata_next;
   logic [1:0]                 resp_reg;
   logic [1:0]                 resp_next;

   cerr_ctrl_s                 ctrl_reg;
   cerr_ctrl_s                 ctrl_next;
   cerr_status_s               stat_reg;
   cerr_status_s               stat_next;
   cerr_result_s               res_reg;
   cerr_result_s               res_next;

   logic [`CERR_IDX_W-1:0]     idx;
   logic [`CERR_IDX_W-1:0]     pos_off;
   logic [`CERR_IDX_W-1:0]     str_off;
   logic                       aligned;
   logic                       hit_pos;
   logic                       hit_str;
   logic                       hit_ctrl;
   logic                       hit_stat;
   logic                       mapped;
   logic                       wr_take;
   logic                       capture;
   logic [`CERR_DATA_W-1:0]    rd_word;
   logic [15:0]                pos_word [`CERR_WORDS];
   logic [15:0]                str_word [`CERR_WORDS];

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------
   assign idx     = avs_address[`CERR_ADDR_W-1:2];
   assign aligned = (avs_address[1:0] == 2'h0);
   assign pos_off = idx - `CERR_IDX_ECHO_POSITION_PAIR_1;
   assign str_off = idx - `CERR_IDX_ECHO_STRENGTH_PAIR_1;

   // positions run contiguously from pair a, strengths likewise
   assign hit_pos  = aligned
                   && (idx >= `CERR_IDX_ECHO_POSITION_PAIR_1)
                   && (idx <= `CERR_IDX_ECHO_POSITION_PAIR_10);
   assign hit_str  = aligned
                   && (idx >= `CERR_IDX_ECHO_STRENGTH_PAIR_1)
                   && (idx <= `CERR_IDX_ECHO_STRENGTH_LAST);
   assign hit_ctrl = aligned && (idx == `CERR_IDX_CTRL);
   assign hit_stat = aligned && (idx == `CERR_IDX_STATUS);
   assign mapped   = hit_pos || hit_str || hit_ctrl || hit_stat;

   // ------------------------------------------------------------------
   // packing of echo entries into 16-bit words
   // ------------------------------------------------------------------
   // word k holds entries 2k (low) and 2k+1 (high); since entry order is
   // pair-major this lands a5/b1 at 0x192 and c5/d1 at 0x197
   generate
      for (genvar k = 0; k < `CERR_WORDS; k++) begin : g_word
         assign pos_word[k] = {res_reg.position[2*k+1],
                               res_reg.position[2*k]};
         assign str_word[k] = {1'b0, res_reg.strength[2*k+1],
                               1'b0, res_reg.strength[2*k]};
      end
   endgenerate

   // ------------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------------
   // narrow registers sit in the low half; upper bits read as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      if (hit_pos) begin
         rd_word = {16'h0000, pos_word[pos_off[3:0]]};
      end else if (hit_str) begin
         rd_word = {16'h0000, str_word[str_off[3:0]]};
      end else if (hit_ctrl) begin
         rd_word = {31'h0000_0000, ctrl_reg.freeze};
      end else if (hit_stat) begin
         rd_word = {16'h0000, stat_reg.count, 5'h00,
                    stat_reg.busy, stat_reg.missed, stat_reg.valid};
      end
   end

   // ------------------------------------------------------------------
   // bus handshake: one wait cycle, then a single-cycle acknowledge
   // ------------------------------------------------------------------
   // read data is sampled on entry to ack so a capture on that same
   // edge cannot tear a word; reads touch no state
   always_comb begin
      state_next = state_reg;
      wait_next  = wait_reg;
      rdata_next = rdata_reg;
      resp_next  = resp_reg;
      case (state_reg)
         CERR_IDLE: begin
            if (avs_read || avs_write) begin
               state_next = CERR_ACK;
               wait_next  = 1'b0;
               rdata_next = avs_read ? rd_word : 32'h0000_0000;
               resp_next  = mapped ? `CERR_RESP_OKAY : `CERR_RESP_SLVERR;
            end
         end
         CERR_ACK: begin
            state_next = CERR_IDLE;
            wait_next  = 1'b1;
         end
         default: begin
            state_next = CERR_IDLE;
            wait_next  = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= CERR_IDLE;
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h0000_0000;
         resp_reg  <= `CERR_RESP_OKAY;
      end else begin
         state_reg <= state_next;
         wait_reg  <= wait_next;
         rdata_reg <= rdata_next;
         resp_reg  <= resp_next;
      end
   end

   // a write lands only on the edge where waitrequest is seen low
   assign wr_take = (state_reg == CERR_ACK) && avs_write;

   // ------------------------------------------------------------------
   // control: freeze holds the last results while software reads them
   // ------------------------------------------------------------------
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_take && hit_ctrl && avs_byteenable[0]) begin
         ctrl_next.freeze = avs_writedata[`CERR_CTRL_FREEZE_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // ------------------------------------------------------------------
   // result store
   // ------------------------------------------------------------------
   // writes to result words are accepted and dropped: no path from the
   // bus reaches res_next
   assign capture = meas_done && !ctrl_reg.freeze;

   always_comb begin
      res_next = res_reg;
      if (capture) begin
         res_next = meas_result;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         for (int e = 0; e < `CERR_ECHOES; e++) begin
            res_reg.position[e] <= `CERR_POS_RESET;
            res_reg.strength[e] <= `CERR_STR_RESET;
         end
      end else begin
         res_reg <= res_next;
      end
   end

   // ------------------------------------------------------------------
   // status
   // ------------------------------------------------------------------
   // missed flags a completion dropped by freeze; write one clears it,
   // but a new drop in the same cycle wins
   always_comb begin
      stat_next      = stat_reg;
      stat_next.busy = meas_busy;
      if (wr_take && hit_stat && avs_byteenable[0]
          && avs_writedata[`CERR_STAT_MISSED_BIT]) begin
         stat_next.missed = 1'b0;
      end
      if (meas_done && ctrl_reg.freeze) begin
         stat_next.missed = 1'b1;
      end
      if (capture) begin
         stat_next.valid = 1'b1;
         stat_next.count = stat_reg.count + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         stat_reg       <= '0;
         stat_reg.count <= `CERR_COUNT_RESET;
      end else begin
         stat_reg <= stat_next;
      end
   end

   // ------------------------------------------------------------------
   // outputs, all straight from flip-flops
   // ------------------------------------------------------------------
   assign avs_readdata    = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign avs_response    = resp_reg;
   assign result_valid    = stat_reg.valid;

endmodule

/* File: bench/cerr_regs_sva.sv */
// concurrent checks on the ports of the echo result register bank
`include "cerr_consts.svh"

module cerr_regs_chk
   import cerr_pkg::*;
(
   // clock and reset
   input wire logic                    clk,
   input wire logic                    reset,
   // avalon-mm slave
   input wire logic [`CERR_ADDR_W-1:0] avs_address,
   input wire logic                    avs_read,
   input wire logic                    avs_write,
   input wire logic [`CERR_DATA_W-1:0] avs_writedata,
   input wire logic [`CERR_BE_W-1:0]   avs_byteenable,
   input wire logic [`CERR_DATA_W-1:0] avs_readdata,
   input wire logic                    avs_waitrequest,
   input wire logic [1:0]              avs_response,
   // measurement engine and status
   input wire logic                    meas_done,
   input wire logic                    meas_busy,
   input wire cerr_result_s            meas_result,
   input wire logic                    result_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   wire [9:0] idx = avs_address[11:2];
   wire       ack = !avs_waitrequest;

   a_ack_single: assert property (
      $fell(avs_waitrequest) |=> avs_waitrequest)
      else $error("ack longer than one cycle");
   a_req_answer: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> ack)
      else $error("request not answered next cycle");
   a_upper_zero: assert property (
      ack |-> avs_readdata[31:16] == 16'h0000)
      else $error("upper half of readdata not zero");
   a_amp_rsvd: assert property (
      ack && avs_read && idx >= 10'h19A && idx <= 10'h1A3
      |-> !avs_readdata[15] && !avs_readdata[7])
      else $error("reserved strength bits set");
   a_reset_clear: assert property (
      $past(reset) |-> avs_waitrequest && avs_readdata == 32'h0
      && !result_valid)
      else $error("outputs not cleared by reset");
   a_write_quiet: assert property (
      ack && avs_write |-> avs_readdata == 32'h0)
      else $error("write ack carries data");
   a_loc_okay: assert property (
      ack && avs_read && avs_address[1:0] == 2'h0
      && idx >= 10'h190 && idx <= 10'h199 |-> avs_response == 2'h0)
      else $error("position read refused");
   a_valid_cause: assert property (
      $rose(result_valid) |-> $past(meas_done))
      else $error("valid rose without completion");
   a_valid_keep: assert property (
      result_valid |=> result_valid)
      else $error("valid dropped");

   c_capture: cover property ($rose(result_valid));
   c_write: cover property (ack && avs_write);
   c_refuse: cover property (ack && avs_response == 2'h2);
endmodule

bind cerr_regs cerr_regs_chk u_chk (.clk(clk), .reset(reset),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .avs_response(avs_response), .meas_done(meas_done),
   .meas_busy(meas_busy), .meas_result(meas_result),
   .result_valid(result_valid));

/* File: bench/testbench.sv */
// self-checking bench for the echo result register bank
`include "cerr_consts.svh"

module testbench
   import cerr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic         clk, reset, rd, wr, done, busy, waitreq, vld, frz;
   logic [11:0]  addr;
   logic [31:0]  wdata, rdata, q;
   logic [1:0]   resp, rsp;
   cerr_result_s res;
   int           failures, n_tests, pm[20], sm[20], ncap;
   logic         miss = 1'b0;
   logic [31:0]  seed = 32'h602A2330;

   cerr_regs u_dut (.clk(clk), .reset(reset), .avs_address(addr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
      .avs_byteenable(4'hF), .avs_readdata(rdata),
      .avs_waitrequest(waitreq), .avs_response(resp), .meas_done(done),
      .meas_busy(busy), .meas_result(res), .result_valid(vld));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // model word k counts from the first position word
   function logic [31:0] expw(int k);
      int j;
      j = 2 * (k % 10);
      if (k < 10) return {16'h0000, pm[j+1][7:0], pm[j][7:0]};
      return {16'h0000, 1'b0, sm[j+1][6:0], 1'b0, sm[j][6:0]};
   endfunction

   task stop_test();
      if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask

   // entered right after a rising edge; leaves one idle edge behind
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      addr <= a;
      wdata <= d;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      if (n >= 50) begin
         failures++;
         stop_test();
      end
      q = rdata;
      rsp = resp;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task sweep();
      for (int k = 0; k < 20; k++) begin
         bus(1'b0, 12'h640 + 12'(4 * k), xs());
         chk(q, expw(k));
         chk({30'h0, rsp}, 32'h0);
      end
      // status: count, busy, missed, valid; result_valid pin too
      bus(1'b0, 12'h6A4, xs());
      chk(q, {16'h0000, 8'(ncap), 5'h00, busy, miss, 1'(ncap > 0)});
      chk({31'h0, vld}, {31'h0, 1'(ncap > 0)});
   endtask

   // writes aimed at result words must leave them alone
   task wrall();
      for (int k = 0; k < 20; k++) begin
         bus(1'b1, 12'h640 + 12'(4 * k), xs());
         chk({30'h0, rsp}, 32'h0);
      end
   endtask

   task cap(int n);
      cerr_result_s r;
      repeat (n) begin
         if (!frz) ncap++;
         else miss = 1'b1;
         for (int e = 0; e < 20; e++) begin
            r.position[e] = 8'(xs());
            r.strength[e] = 7'(xs());
            if (!frz) pm[e] = r.position[e];
            if (!frz) sm[e] = r.strength[e];
         end
         res <= r;
         done <= 1'b1;
         busy <= 1'(xs());
         @(posedge clk);
      end
      done <= 1'b0;
      @(posedge clk);
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      stop_test();
   end

   initial begin
      reset = 1'b1;
      {rd, wr, done, busy, frz} = 5'h00;
      addr = 12'h000;
      wdata = 32'h0;
      res = '0;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      sweep();
      cap(1);
      sweep();
      sweep();
      wrall();
      sweep();
      cap(3);
      sweep();
      bus(1'b1, 12'h6A0, 32'h1);
      frz = 1'b1;
      cap(2);
      sweep();
      bus(1'b1, 12'h6A0, 32'h0);
      frz = 1'b0;
      // missed is write-one-to-clear
      bus(1'b1, 12'h6A4, 32'h2);
      miss = 1'b0;
      for (int i = 0; i < 4; i++) begin
         cap(1);
         sweep();
      end
      bus(1'b0, 12'h642, xs());
      chk(q, 32'h0);
      chk({30'h0, rsp}, 32'h2);
      // reset in mid-run clears every result
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      foreach (pm[e]) begin
         pm[e] = 0;
         sm[e] = 0;
      end
      ncap = 0;
      miss = 1'b0;
      sweep();
      stop_test();
   end
endmodule
